// file: design/mmd_regs.svh
// address map constants and counts of the memory map decoder
// How it works
// R1: masters share one 16 MB byte-addressed program and data space.
// R2: a separate 64K-word I/O space is decoded apart from memory.
// R3: bytes 000000h-00FFFFh select dual-access RAM, eight 8 KB blocks.
// R4: each dual-access RAM block serves two accesses in one cycle.
// R5: DMA reaches dual-access RAM through window at 0001_0000h, block 0 first.
// R6: lowest 192 bytes decode as CPU mapped registers, not RAM.
// R7: bytes 010000h-03FFFFh select single-access RAM, 24 blocks.
// R8: each single-access RAM block serves at most one access per cycle.
// R9: DMA and USB reach single-access RAM through window at 0009_0000h.
// R10: DMA window 000C_0000h-000C_FFFFh is reserved and maps nowhere.
// R11: bytes FE0000h-FFFFFFh select the ROM, four 32 KB blocks.
// R12: remap bit zero routes the top 128 KB to on-chip ROM.
// R13: remap bit one removes ROM and routes that region externally.
// R14: hardware reset clears the remap bit.
// R15: software reset leaves the remap bit unchanged.
// R16: ROM serves program and data buses, one word per block per cycle.
// R17: bytes 050000h upward are external space in chip selects 0 to 3.
// R18: a chip select is asserted exactly when an access hits its region.
// R19: external port has 16- or 8-bit data and up to 21 address bits.
// R20: software configures the external port before external accesses.
// R21: only DMA controller 3 reaches external space; USB never dual RAM.
// R22: colliding masters on one block are served by fixed priority.
// R23: reserved accesses complete harmlessly and read as zero.
`ifndef MMD_REGS_SVH
`define MMD_REGS_SVH
`define MMD_NM 4
`define MMD_M_DMA 2
`define MMD_M_USB 3
`define MMD_IO_AW 16
`define MMD_MMR_END 24'h0000c0
`define MMD_DUAL_HI 24'h00ffff
`define MMD_SINGLE_HI 24'h03ffff
`define MMD_EXT_LO 24'h050000
`define MMD_ROM_LO 24'hfe0000
`define MMD_SINGLE_BLK0 5'h08
`define MMD_DMA_DA_LO 32'h00010000
`define MMD_DMA_DA_HI 32'h0001ffff
`define MMD_DMA_DA_SHIFT 24'h010000
`define MMD_DMA_SA_LO 32'h00090000
`define MMD_DMA_SA_HI 32'h000bffff
`define MMD_DMA_SA_SHIFT 24'h080000
`define MMD_DMA_RSV_LO 32'h000c0000
`define MMD_DMA_RSV_HI 32'h000cffff
`define MMD_DMA_EXT_TAG 8'h01
`define MMD_DMA_EXT_ID 2'h3
`define MMD_EXT_AW_MAX 21
`define MMD_REMAP_RST 1'b0
`define MMD_CS_IDLE 4'hf
`endif

// file: design/mmd_pkg.sv
// types of the memory map decoder
package mmd_pkg;
	typedef enum logic [5:0] {
		RG_NONE = 6'h01,
		RG_MMR = 6'h02,
		RG_DUAL = 6'h04,
		RG_SINGLE = 6'h08,
		RG_ROM = 6'h10,
		RG_EXT = 6'h20
	} mmd_region_t;
endpackage

// file: design/mmd_decoder.sv
// memory map decoder and router for cpu, dma and usb masters
`timescale 1ns/1ps
`include "mmd_regs.svh"
module mmd_decoder import mmd_pkg::*; #(
	parameter int EXT_AW = `MMD_EXT_AW_MAX
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// master requests: 0 data, 1 program, 2 dma, 3 usb
	input wire logic [3:0] REQ,
	input wire logic [23:0] D_ADDR,
	input wire logic [23:0] P_ADDR,
	input wire logic [31:0] M_ADDR,
	input wire logic [1:0] M_ID,
	input wire logic [31:0] U_ADDR,
	// routing answers
	output logic [3:0] GNT,
	output logic [3:0] STALL,
	output logic [3:0] ZERO_RD,
	output mmd_region_t REGION [4],
	output logic [4:0] BLK [4],
	output logic [14:0] OFS [4],
	// i/o space
	input wire logic IO_REQ,
	input wire logic [15:0] IO_ADDR,
	output logic IO_SEL,
	output logic [15:0] IO_WADDR,
	// external memory port
	input wire logic EXT_BUS16,
	output logic [3:0] EXT_CS_N,
	output logic [EXT_AW-1:0] EXT_ADDR,
	// status register three remap bit
	input wire logic STATUS_WR,
	input wire logic STATUS_REMAP,
	input wire logic SOFT_RST,
	output logic ROM_REMAP
);

	if (EXT_AW < 1 || EXT_AW > `MMD_EXT_AW_MAX) begin : g_bad_aw
		$error("EXT_AW out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic mmd_region_t cpu_region(input logic [23:0] a, input logic remap);
		if (a < `MMD_MMR_END)
			return RG_MMR; // R6
		else if (a <= `MMD_DUAL_HI)
			return RG_DUAL; // R3
		else if (a <= `MMD_SINGLE_HI)
			return RG_SINGLE; // R7
		else if (a < `MMD_EXT_LO)
			return RG_NONE; // R23
		else if (a >= `MMD_ROM_LO && !remap)
			return RG_ROM; // R11 R12
		else
			return RG_EXT; // R13 R17
	endfunction

	function automatic logic [4:0] cpu_block(input logic [23:0] a, input mmd_region_t r);
		case (r)
			RG_MMR, RG_DUAL: return {2'h0, a[15:13]};
			RG_SINGLE: return a[17:13] - `MMD_SINGLE_BLK0;
			RG_ROM: return {3'h0, a[16:15]};
			RG_EXT: return {3'h0, a[23:22]};
			default: return 5'h00;
		endcase
	endfunction

	// dma view to cpu byte address; top bit says the window is mapped
	function automatic logic [24:0] dma_xlat(input logic [31:0] a);
		if (a >= `MMD_DMA_DA_LO && a <= `MMD_DMA_DA_HI)
			return {1'b1, a[23:0] - `MMD_DMA_DA_SHIFT}; // R5
		else if (a >= `MMD_DMA_SA_LO && a <= `MMD_DMA_SA_HI)
			return {1'b1, a[23:0] - `MMD_DMA_SA_SHIFT}; // R9
		else if (a[31:24] == `MMD_DMA_EXT_TAG)
			return {1'b1, a[23:0]};
		else
			return 25'h0000000; // R10
	endfunction

	// two accesses meet on one storage resource
	function automatic logic same_res(input mmd_region_t ra, input logic [4:0] ba,
			input mmd_region_t rb, input logic [4:0] bb);
		return (ra == rb) && (ra == RG_EXT || (ra != RG_NONE && ra != RG_MMR && ba == bb));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// address decode

	logic remap_q;
	logic [24:0] m_x;
	logic [24:0] u_x;
	logic [23:0] ca [4];
	logic [3:0] ok;
	logic [3:0] ew;
	mmd_region_t rg [4];
	logic [4:0] bk [4];
	logic [3:0] stall;
	logic ext_hit;
	logic [1:0] ext_w;
	logic [23:0] ext_a;

	assign m_x = dma_xlat(M_ADDR);
	assign u_x = dma_xlat(U_ADDR);
	assign ca[0] = D_ADDR; // R1
	assign ca[1] = P_ADDR;
	assign ca[2] = m_x[23:0];
	assign ca[3] = u_x[23:0];
	assign ok = {u_x[24], m_x[24], 2'b11};
	assign ew = {U_ADDR[31:24] == `MMD_DMA_EXT_TAG, M_ADDR[31:24] == `MMD_DMA_EXT_TAG, 2'b00};

	always_comb begin
		for (int i = 0; i < `MMD_NM; i++) begin
			rg[i] = cpu_region(ca[i], remap_q);
			if (i >= `MMD_M_DMA) begin
				if (!ok[i] || rg[i] == RG_ROM || rg[i] == RG_NONE || ((rg[i] == RG_EXT) != ew[i]))
					rg[i] = RG_NONE; // R16 R23
				else if (rg[i] == RG_MMR)
					rg[i] = RG_DUAL;
			end
		end
		if (rg[`MMD_M_DMA] == RG_EXT && M_ID != `MMD_DMA_EXT_ID)
			rg[`MMD_M_DMA] = RG_NONE; // R21
		if (rg[`MMD_M_USB] == RG_EXT || rg[`MMD_M_USB] == RG_DUAL)
			rg[`MMD_M_USB] = RG_NONE; // R21
		for (int i = 0; i < `MMD_NM; i++)
			bk[i] = cpu_block(ca[i], rg[i]);
	end

	////////////////////////////////////////////////////////////////////////
	// fixed priority: data, program, dma, usb

	always_comb begin
		logic [1:0] n;
		n = 2'h0;
		for (int i = 0; i < `MMD_NM; i++) begin
			n = 2'h0;
			for (int j = 0; j < i; j++)
				if (REQ[j] && same_res(rg[j], bk[j], rg[i], bk[i]))
					n = n + 2'h1;
			// dual-access blocks take two, mapped registers and reserved accesses any number, all others one
			stall[i] = REQ[i] && ((rg[i] == RG_DUAL) ? (n >= 2'h2) : (n != 2'h0)); // R4 R8 R22
		end
	end

	always_comb begin
		ext_hit = 1'b0;
		ext_w = 2'h0;
		for (int i = `MMD_NM - 1; i >= 0; i--)
			if (REQ[i] && !stall[i] && rg[i] == RG_EXT) begin
				ext_hit = 1'b1;
				ext_w = 2'(i);
			end
	end
	assign ext_a = ca[ext_w];

	////////////////////////////////////////////////////////////////////////
	// registered answers

	logic [3:0] gnt_q;
	logic [3:0] stall_q;
	logic [3:0] zero_q;
	mmd_region_t region_q [4];
	logic [4:0] blk_q [4];
	logic [14:0] ofs_q [4];
	logic io_sel_q;
	logic [15:0] io_waddr_q;
	logic [3:0] cs_n_q;
	logic [EXT_AW-1:0] ext_addr_q;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			gnt_q <= 4'h0;
			stall_q <= 4'h0;
			zero_q <= 4'h0;
			for (int i = 0; i < `MMD_NM; i++) begin
				region_q[i] <= RG_NONE;
				blk_q[i] <= 5'h00;
				ofs_q[i] <= 15'h0000;
			end
		end else begin
			gnt_q <= REQ & ~stall;
			stall_q <= stall;
			for (int i = 0; i < `MMD_NM; i++) begin
				zero_q[i] <= REQ[i] && rg[i] == RG_NONE; // R23
				region_q[i] <= rg[i];
				blk_q[i] <= bk[i];
				ofs_q[i] <= (rg[i] == RG_ROM) ? ca[i][14:0] : {2'h0, ca[i][12:0]};
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			io_sel_q <= 1'b0;
			io_waddr_q <= 16'h0000;
		end else begin
			io_sel_q <= IO_REQ; // R2
			io_waddr_q <= IO_ADDR;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cs_n_q <= `MMD_CS_IDLE;
			ext_addr_q <= '0;
		end else begin
			cs_n_q <= ext_hit ? ~(4'h1 << ext_a[23:22]) : `MMD_CS_IDLE; // R17 R18
			if (ext_hit)
				ext_addr_q <= EXT_BUS16 ? ext_a[EXT_AW:1] : ext_a[EXT_AW-1:0]; // R19
		end
	end

	// soft reset is deliberately not wired here
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			remap_q <= `MMD_REMAP_RST; // R14
		else if (STATUS_WR)
			remap_q <= STATUS_REMAP; // R15
	end

	assign GNT = gnt_q;
	assign STALL = stall_q;
	assign ZERO_RD = zero_q;
	assign REGION = region_q;
	assign BLK = blk_q;
	assign OFS = ofs_q;
	assign IO_SEL = io_sel_q;
	assign IO_WADDR = io_waddr_q;
	assign EXT_CS_N = cs_n_q;
	assign EXT_ADDR = ext_addr_q;
	assign ROM_REMAP = remap_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_mmr;
		@(posedge CLK) disable iff (!RST_N)
		REQ[0] && D_ADDR < `MMD_MMR_END |=> GNT[0] && REGION[0] == RG_MMR;
	endproperty
	a_mmr: assert property (p_mmr) else $error("mapped register decode wrong"); // R6

	property p_dual_blk;
		@(posedge CLK) disable iff (!RST_N)
		REQ[1] && P_ADDR >= `MMD_MMR_END && P_ADDR <= `MMD_DUAL_HI
		|=> REGION[1] == RG_DUAL && BLK[1] == {2'h0, $past(P_ADDR[15:13])};
	endproperty
	a_dual_blk: assert property (p_dual_blk) else $error("dual ram block wrong"); // R3

	property p_dual;
		@(posedge CLK) disable iff (!RST_N)
		REQ[0] && REQ[1] && D_ADDR >= `MMD_MMR_END && D_ADDR <= `MMD_DUAL_HI
		&& P_ADDR[23:13] == D_ADDR[23:13] |=> GNT[1:0] == 2'b11;
	endproperty
	a_dual: assert property (p_dual) else $error("dual ram refused a second access"); // R4

	property p_dma_win;
		@(posedge CLK) disable iff (!RST_N)
		REQ[2] && M_ADDR == `MMD_DMA_DA_LO |=> REGION[2] == RG_DUAL && BLK[2] == 5'h00
		&& OFS[2] == 15'h0000;
	endproperty
	a_dma_win: assert property (p_dma_win) else $error("dma dual window wrong"); // R5

	property p_single;
		@(posedge CLK) disable iff (!RST_N)
		REQ[0] && REQ[1] && D_ADDR > `MMD_DUAL_HI && D_ADDR <= `MMD_SINGLE_HI
		&& P_ADDR[23:13] == D_ADDR[23:13] |=> GNT[0] && !GNT[1] && STALL[1];
	endproperty
	a_single: assert property (p_single) else $error("single ram served two"); // R8

	property p_usb;
		@(posedge CLK) disable iff (!RST_N)
		REQ[3] && U_ADDR >= `MMD_DMA_DA_LO && U_ADDR <= `MMD_DMA_DA_HI
		|=> REGION[3] == RG_NONE && ZERO_RD[3];
	endproperty
	a_usb: assert property (p_usb) else $error("usb reached dual ram"); // R21

	property p_rsv;
		@(posedge CLK) disable iff (!RST_N)
		REQ[2] && M_ADDR >= `MMD_DMA_RSV_LO && M_ADDR <= `MMD_DMA_RSV_HI
		|=> REGION[2] == RG_NONE && GNT[2] && EXT_CS_N == `MMD_CS_IDLE;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved dma window mapped"); // R10

	property p_rom;
		@(posedge CLK) disable iff (!RST_N)
		REQ[1] && P_ADDR >= `MMD_ROM_LO
		|=> REGION[1] == ($past(ROM_REMAP) ? RG_EXT : RG_ROM);
	endproperty
	a_rom: assert property (p_rom) else $error("rom remap decode wrong"); // R13

	property p_soft;
		@(posedge CLK) disable iff (!RST_N)
		SOFT_RST && !STATUS_WR |=> $stable(ROM_REMAP);
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset changed remap"); // R15

	property p_cs;
		@(posedge CLK) disable iff (!RST_N)
		EXT_CS_N != `MMD_CS_IDLE |-> $onehot(~EXT_CS_N)
		&& $past(ext_hit) && ($past(REQ[1:0]) != 2'b00 || $past(REQ[2]));
	endproperty
	a_cs: assert property (p_cs) else $error("chip select without access"); // R18

	c_dual: cover property (@(posedge CLK) disable iff (!RST_N) GNT[1:0] == 2'b11
		&& REGION[0] == RG_DUAL && REGION[1] == RG_DUAL);
	c_stall: cover property (@(posedge CLK) disable iff (!RST_N) STALL[3] && REGION[3] == RG_SINGLE);
	c_ext: cover property (@(posedge CLK) disable iff (!RST_N) GNT[2] && REGION[2] == RG_EXT);
	c_remap: cover property (@(posedge CLK) disable iff (!RST_N) ROM_REMAP && REGION[1] == RG_EXT);

endmodule

// file: dv/mmd_masters.sv
// request model of the cpu data and program buses, the dma controllers and usb
`timescale 1ns/1ps
module mmd_masters (
	// clock
	input wire logic clk,
	// requests toward the decoder
	output logic [3:0] req,
	output logic [23:0] d_addr,
	output logic [23:0] p_addr,
	output logic [31:0] m_addr,
	output logic [1:0] m_id,
	output logic [31:0] u_addr
);
	initial begin
		req = 4'h0;
		d_addr = 24'h000000;
		p_addr = 24'h000000;
		m_addr = 32'h00000000;
		m_id = 2'h0;
		u_addr = 32'h00000000;
	end

	////////////////////////////////////////////////////////////////////////////
	// one request cycle after gap + 1 idle cycles; then req drops to zero and the address and id lines show the inverse
	task automatic issue(input int gap, input logic [3:0] r, input logic [23:0] d,
		input logic [23:0] p, input logic [31:0] m, input logic [1:0] id,
		input logic [31:0] u);
		repeat (gap + 1) @(negedge clk);
		req = r;
		d_addr = d;
		p_addr = p;
		m_addr = m;
		m_id = id;
		u_addr = u;
		@(negedge clk);
		req = 4'h0;
		d_addr = ~d;
		p_addr = ~p;
		m_addr = ~m;
		m_id = ~id;
		u_addr = ~u;
	endtask
endmodule

// file: dv/testbench.sv
// self-checking bench of the memory map decoder
`timescale 1ns/1ps
module testbench import mmd_pkg::*; ();
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] req;
	logic [23:0] d_addr;
	logic [23:0] p_addr;
	logic [31:0] m_addr;
	logic [1:0] m_id;
	logic [31:0] u_addr;
	logic [3:0] gnt;
	logic [3:0] stall;
	logic [3:0] zero_rd;
	mmd_region_t region [4];
	logic [4:0] blk [4];
	logic [14:0] ofs [4];
	logic io_req = 1'b0;
	logic [15:0] io_addr = 16'h0000;
	logic io_sel;
	logic [15:0] io_waddr;
	logic ext_bus16 = 1'b1;
	logic [3:0] ext_cs_n;
	logic [20:0] ext_addr;
	logic status_wr = 1'b0;
	logic status_remap = 1'b0;
	logic soft_rst = 1'b0;
	logic rom_remap;
	int miscompares = 0;
	int comparisons = 0;

	always #20 clk = ~clk;

	mmd_masters mst (.clk(clk), .req(req), .d_addr(d_addr), .p_addr(p_addr),
		.m_addr(m_addr), .m_id(m_id), .u_addr(u_addr));

	mmd_decoder #(.EXT_AW(21)) dut (.CLK(clk), .RST_N(rst_n), .REQ(req), .D_ADDR(d_addr),
		.P_ADDR(p_addr), .M_ADDR(m_addr), .M_ID(m_id), .U_ADDR(u_addr), .GNT(gnt),
		.STALL(stall), .ZERO_RD(zero_rd), .REGION(region), .BLK(blk), .OFS(ofs),
		.IO_REQ(io_req), .IO_ADDR(io_addr), .IO_SEL(io_sel), .IO_WADDR(io_waddr),
		.EXT_BUS16(ext_bus16), .EXT_CS_N(ext_cs_n), .EXT_ADDR(ext_addr),
		.STATUS_WR(status_wr), .STATUS_REMAP(status_remap), .SOFT_RST(soft_rst),
		.ROM_REMAP(rom_remap));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic route(input int i, input logic [31:0] rg, input logic [31:0] b,
		input logic [31:0] o);
		check("region", region[i], rg);
		check("block", blk[i], b);
		check("offset", ofs[i], o);
	endtask

	task automatic answer(input logic [3:0] g, input logic [3:0] s, input logic [3:0] z);
		check("grant", gnt, g);
		check("stall", stall, s);
		check("zero read", zero_rd, z);
	endtask

	task automatic give_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_cpu_ram;
		mst.issue(0, 4'h1, 24'h002010, 0, 0, 0, 0);
		route(0, RG_DUAL, 1, 15'h0010);
		mst.issue(1, 4'h1, 24'h0000bf, 0, 0, 0, 0);
		route(0, RG_MMR, 0, 15'h00bf);
		mst.issue(0, 4'h1, 24'h0000c0, 0, 0, 0, 0);
		route(0, RG_DUAL, 0, 15'h00c0);
		mst.issue(0, 4'h3, 24'h006000, 24'h006002, 0, 0, 0);
		answer(4'h3, 4'h0, 4'h0);
		mst.issue(0, 4'h1, 24'h03e004, 0, 0, 0, 0);
		route(0, RG_SINGLE, 23, 15'h0004);
		mst.issue(0, 4'h3, 24'h012000, 24'h013ffe, 0, 0, 0);
		answer(4'h1, 4'h2, 4'h0);
		mst.issue(0, 4'h2, 0, 24'h013ffe, 0, 0, 0);
		route(1, RG_SINGLE, 1, 15'h1ffe);
		mst.issue(0, 4'h1, 24'h040000, 0, 0, 0, 0);
		route(0, RG_NONE, 0, 0);
		answer(4'h1, 4'h0, 4'h1);
	endtask

	task automatic t_dma_usb;
		mst.issue(0, 4'h4, 0, 0, 32'h00012004, 2'h0, 0);
		route(2, RG_DUAL, 1, 15'h0004);
		mst.issue(0, 4'h4, 0, 0, 32'h00010000, 2'h0, 0);
		route(2, RG_DUAL, 0, 0);
		mst.issue(0, 4'h4, 0, 0, 32'h00092000, 2'h1, 0);
		route(2, RG_SINGLE, 1, 0);
		mst.issue(0, 4'h4, 0, 0, 32'h000c0000, 2'h2, 0);
		answer(4'h4, 4'h0, 4'h4);
		mst.issue(0, 4'h8, 0, 0, 0, 0, 32'h00090000);
		route(3, RG_SINGLE, 0, 0);
		mst.issue(0, 4'h9, 24'h010000, 0, 0, 0, 32'h00090000);
		answer(4'h1, 4'h8, 4'h0);
		mst.issue(0, 4'h8, 0, 0, 0, 0, 32'h00010000);
		answer(4'h8, 4'h0, 4'h8);
		mst.issue(0, 4'h4, 0, 0, 32'h01050000, 2'h0, 0);
		answer(4'h4, 4'h0, 4'h4);
		check("cs idle", ext_cs_n, 4'hf);
		mst.issue(0, 4'h4, 0, 0, 32'h01050000, 2'h3, 0);
		route(2, RG_EXT, 0, 0);
		check("cs", ext_cs_n, 4'he);
	endtask

	task automatic t_external;
		ext_bus16 = 1'b1;
		mst.issue(0, 4'h1, 24'h050000, 0, 0, 0, 0);
		check("cs", ext_cs_n, 4'he);
		check("ext addr", ext_addr, 21'h028000);
		ext_bus16 = 1'b0;
		mst.issue(0, 4'h1, 24'h400003, 0, 0, 0, 0);
		check("cs", ext_cs_n, 4'hd);
		check("ext addr", ext_addr, 21'h000003);
		@(negedge clk);
		check("cs idle", ext_cs_n, 4'hf);
		mst.issue(0, 4'h3, 24'h800000, 24'hc00000, 0, 0, 0);
		answer(4'h1, 4'h2, 4'h0);
		check("cs", ext_cs_n, 4'hb);
	endtask

	task automatic t_rom_remap;
		mst.issue(0, 4'h1, 24'hfe0000, 0, 0, 0, 0);
		route(0, RG_ROM, 0, 0);
		mst.issue(0, 4'h2, 0, 24'hffffff, 0, 0, 0);
		route(1, RG_ROM, 3, 15'h7fff);
		@(negedge clk);
		status_wr = 1'b1;
		status_remap = 1'b1;
		@(negedge clk);
		status_wr = 1'b0;
		check("remap", rom_remap, 1'b1);
		mst.issue(0, 4'h1, 24'hfe0000, 0, 0, 0, 0);
		route(0, RG_EXT, 3, 0);
		check("cs", ext_cs_n, 4'h7);
		mst.issue(0, 4'h2, 0, 24'hfe0002, 0, 0, 0);
		route(1, RG_EXT, 3, 15'h0002);
		check("cs", ext_cs_n, 4'h7);
		soft_rst = 1'b1;
		@(negedge clk);
		soft_rst = 1'b0;
		@(negedge clk);
		check("remap", rom_remap, 1'b1);
		rst_n = 1'b0;
		@(negedge clk);
		check("remap", rom_remap, 1'b0);
		rst_n = 1'b1;
		mst.issue(0, 4'h1, 24'hfe0000, 0, 0, 0, 0);
		route(0, RG_ROM, 0, 0);
	endtask

	task automatic t_io;
		@(negedge clk);
		io_req = 1'b1;
		io_addr = 16'h1c00;
		@(negedge clk);
		io_req = 1'b0;
		check("io select", io_sel, 1'b1);
		check("io address", io_waddr, 16'h1c00);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clk);
		check("remap", rom_remap, 1'b0);
		check("cs idle", ext_cs_n, 4'hf);
		rst_n = 1'b1;
		t_cpu_ram();
		t_dma_usb();
		t_external();
		t_rom_remap();
		t_io();
		give_verdict();
	end

	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
endmodule
